/* File: core/ack_params.svh */
`ifndef ACK_PARAMS_SVH
`define ACK_PARAMS_SVH

// least gap, in serial clock cycles, from command end to the acknowledge low pulse
`define ACK_MIN_DELAY 32
// length of the acknowledge low pulse in serial clock cycles
`define ACK_LOW_CYCLES 16
// counter width that holds either count
`define ACK_CNT_W 6

`endif

/* File: core/ack_pkg.sv */
package ack_pkg;

    typedef enum logic [2:0] {
        CMD_READ = 3'b000,
        CMD_WRITE = 3'b001,
        CMD_OTHER = 3'b010,
        CMD_BACKGROUND = 3'b011,
        CMD_GO = 3'b100,
        CMD_ACK_ENABLE = 3'b101,
        CMD_ACK_DISABLE = 3'b110
    } cmd_kind_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PEND = 2'b01,
        ST_LOW = 2'b10,
        ST_SPEEDUP = 2'b11
    } ack_state_type;

endpackage : ack_pkg

/* File: core/cnt_if.sv */
interface cnt_if #(
    parameter int W = 6
);
    logic load;
    logic zero;

    modport ctl (output load, input zero);
    modport cnt (input load, output zero);
endinterface : cnt_if

/* File: core/tick_counter.sv */
module tick_counter #(
    parameter int W = 6,
    parameter logic [W-1:0] LOAD = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    cnt_if.cnt c
);
    typedef struct packed {
        logic [W-1:0] count;
    } cnt_st_type;

    cnt_st_type s_r;
    cnt_st_type s_nxt;

    // runs on the serial clock only, so its length never depends on the bus rate
    always_comb begin
        s_nxt = s_r;
        if (c.load) begin
            s_nxt.count = LOAD;
        end else if (s_r.count != '0) begin
            s_nxt.count = s_r.count - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign c.zero = (s_r.count == '0);
endmodule : tick_counter

/* File: core/pin_driver.sv */
module pin_driver (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // requests from the handshake
    input wire logic drive_low,
    input wire logic drive_high,
    // debug_serial_pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_level
);
    typedef struct packed {
        logic out;
        logic oe;
        logic level;
    } pin_st_type;

    pin_st_type s_r;
    pin_st_type s_nxt;

    // no arbitration against a host sync pulse: both may drive at once
    always_comb begin
        s_nxt = s_r;
        s_nxt.out = drive_high;
        s_nxt.oe = drive_low | drive_high;
        s_nxt.level = pin_in;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_out = s_r.out;
    assign pin_oe = s_r.oe;
    assign pin_level = s_r.level;
endmodule : pin_driver

/* File: core/ack_handshake.sv */
`include "ack_params.svh"

module ack_handshake (
    // serial clock and reset
    input wire logic clk,
    input wire logic rst,
    // command decoder
    input wire logic cmd_end,
    input wire ack_pkg::cmd_kind_type cmd_kind,
    // execution events
    input wire logic exec_done,
    input wire logic cpu_to_bkgnd,
    input wire logic cpu_from_bkgnd,
    input wire logic cpu_wait_stop,
    input wire logic sync_req,
    // status
    output logic ack_enabled,
    output logic ack_pending,
    output logic ack_active,
    output logic cmd_dropped,
    // debug_serial_pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_level
);
    typedef struct packed {
        ack_pkg::ack_state_type state;
        ack_pkg::cmd_kind_type kind;
        logic en;
        logic done;
        logic dropped;
    } hs_st_type;

    hs_st_type s_r;
    hs_st_type s_nxt;

    cnt_if #(.W(`ACK_CNT_W)) dly ();
    cnt_if #(.W(`ACK_CNT_W)) len ();

    logic event_hit;
    logic abort_sync;
    logic abort_sleep;

    // loads one less than the figure: the count reaches zero one clock early, so the state moves exactly at the figure
    tick_counter #(
        .W(`ACK_CNT_W),
        .LOAD(`ACK_CNT_W'(`ACK_MIN_DELAY - 1))
    ) u_dly (
        .clk(clk),
        .rst(rst),
        .c(dly)
    );

    tick_counter #(
        .W(`ACK_CNT_W),
        .LOAD(`ACK_CNT_W'(`ACK_LOW_CYCLES - 1))
    ) u_len (
        .clk(clk),
        .rst(rst),
        .c(len)
    );

    // completion point differs per command kind
    always_comb begin
        case (s_r.kind)
            ack_pkg::CMD_READ: event_hit = exec_done;
            ack_pkg::CMD_WRITE: event_hit = exec_done;
            ack_pkg::CMD_OTHER: event_hit = exec_done;
            ack_pkg::CMD_BACKGROUND: event_hit = cpu_to_bkgnd;
            ack_pkg::CMD_GO: event_hit = cpu_from_bkgnd;
            ack_pkg::CMD_ACK_ENABLE: event_hit = 1'b1;
            default: event_hit = 1'b0;
        endcase
    end

    always_comb begin
        abort_sync = sync_req && (s_r.kind == ack_pkg::CMD_BACKGROUND ||
                     s_r.kind == ack_pkg::CMD_GO);
        abort_sleep = cpu_wait_stop && !s_r.done && !event_hit &&
                      s_r.kind != ack_pkg::CMD_ACK_ENABLE;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.dropped = 1'b0;
        dly.load = 1'b0;
        len.load = 1'b0;
        case (s_r.state)
            ack_pkg::ST_IDLE: begin
                if (cmd_end) begin
                    if (cmd_kind == ack_pkg::CMD_ACK_ENABLE) begin
                        s_nxt.en = 1'b1;
                        s_nxt.kind = cmd_kind;
                        s_nxt.done = 1'b0;
                        s_nxt.state = ack_pkg::ST_PEND;
                        dly.load = 1'b1;
                    end else if (cmd_kind == ack_pkg::CMD_ACK_DISABLE) begin
                        s_nxt.en = 1'b0;
                    end else if (s_r.en) begin
                        s_nxt.kind = cmd_kind;
                        s_nxt.done = 1'b0;
                        s_nxt.state = ack_pkg::ST_PEND;
                        dly.load = 1'b1;
                    end
                end
            end
            ack_pkg::ST_PEND: begin
                // a later command end is ignored: the host must wait for the pulse
                if (abort_sync) begin
                    s_nxt.state = ack_pkg::ST_IDLE;
                end else if (abort_sleep) begin
                    s_nxt.dropped = 1'b1;
                    s_nxt.state = ack_pkg::ST_IDLE;
                end else begin
                    if (event_hit) begin
                        s_nxt.done = 1'b1;
                    end
                    if ((s_r.done || event_hit) && dly.zero) begin
                        s_nxt.state = ack_pkg::ST_LOW;
                        len.load = 1'b1;
                    end
                end
            end
            ack_pkg::ST_LOW: begin
                if (len.zero) begin
                    s_nxt.state = ack_pkg::ST_SPEEDUP;
                end
            end
            ack_pkg::ST_SPEEDUP: begin
                s_nxt.state = ack_pkg::ST_IDLE;
                s_nxt.done = 1'b0;
            end
            default: begin
                s_nxt.state = ack_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.state <= ack_pkg::ST_IDLE;
            s_r.kind <= ack_pkg::CMD_READ;
            s_r.en <= 1'b0;
            s_r.done <= 1'b0;
            s_r.dropped <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // pin outputs are registered once more, so the pin lags the state by one clock
    pin_driver u_pin (
        .clk(clk),
        .rst(rst),
        .drive_low(s_r.state == ack_pkg::ST_LOW),
        .drive_high(s_r.state == ack_pkg::ST_SPEEDUP),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pin_level(pin_level)
    );

    assign ack_enabled = s_r.en;
    assign ack_pending = (s_r.state == ack_pkg::ST_PEND);
    assign ack_active = (s_r.state == ack_pkg::ST_LOW) || (s_r.state == ack_pkg::ST_SPEEDUP);
    assign cmd_dropped = s_r.dropped;
endmodule : ack_handshake

/* File: test/ack_handshake_sva.sv */
module ack_handshake_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command and events
    input wire logic cmd_end,
    input wire ack_pkg::cmd_kind_type cmd_kind,
    input wire logic sync_req,
    // status and pin
    input wire logic ack_enabled,
    input wire logic ack_pending,
    input wire logic ack_active,
    input wire logic cmd_dropped,
    input wire logic pin_out,
    input wire logic pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic take;
    logic [5:0] gap_r;
    ack_pkg::cmd_kind_type kind_r;
    assign take = cmd_end && !ack_pending && !ack_active;
    // saturating, so a long wait never wraps into a false short gap
    always_ff @(posedge clk) begin
        gap_r <= (rst || take) ? 6'h00 : gap_r + {5'h00, gap_r != 6'h3f};
        if (take) begin
            kind_r <= cmd_kind;
        end
    end
    property p_low;
        $rose(pin_oe) |-> (pin_oe && !pin_out)[*8] ##1 (pin_oe && !pin_out)[*8]
            ##1 (pin_oe && pin_out) ##1 !pin_oe;
    endproperty
    a_low: assert property (p_low) else $error("bad ack pulse shape");
    // the pin stage lags the handshake state by one clock
    property p_oe; pin_oe |-> $past(ack_active); endproperty
    a_oe: assert property (p_oe) else $error("pin driven outside ack");
    // gap_r seen at the first driven sample equals the clocks from command end to pulse start, saturating at 63
    property p_gap; $rose(pin_oe) |-> gap_r >= 6'h20; endproperty
    a_gap: assert property (p_gap) else $error("ack too early");
    property p_en; take && cmd_kind == ack_pkg::CMD_ACK_ENABLE |=> ack_enabled && ack_pending;
    endproperty
    a_en: assert property (p_en) else $error("enable not taken");
    property p_dis; take && cmd_kind == ack_pkg::CMD_ACK_DISABLE |=> !ack_enabled && !ack_pending;
    endproperty
    a_dis: assert property (p_dis) else $error("disable not taken");
    property p_noack; $rose(pin_oe) |-> ack_enabled; endproperty
    a_noack: assert property (p_noack) else $error("ack while disabled");
    property p_rst; $past(rst) |-> !ack_enabled; endproperty
    a_rst: assert property (p_rst) else $error("enabled after reset");
    property p_drop; cmd_dropped |-> !ack_pending && !ack_active ##1 !cmd_dropped; endproperty
    a_drop: assert property (p_drop) else $error("drop left command");
    property p_sync;
        ack_pending && sync_req && kind_r inside {ack_pkg::CMD_BACKGROUND, ack_pkg::CMD_GO}
            |=> !ack_pending && !pin_oe;
    endproperty
    a_sync: assert property (p_sync) else $error("sync did not abort");
    c_ack: cover property ($fell(pin_oe));
    c_drop: cover property (cmd_dropped);
    c_abort: cover property ($fell(ack_pending) && !ack_active);
endmodule : ack_handshake_chk

bind ack_handshake ack_handshake_chk chk (.*);

/* File: test/dbg_host_model.sv */
module dbg_host_model (
    // target side of debug_serial_pin
    input wire logic pin_out,
    input wire logic pin_oe,
    // host pulls low for a sync request
    input wire logic host_low,
    output logic pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up when released; a sync over a speedup pulse simply reads low
    assign pin_in = (pin_oe ? pin_out : 1'b1) & !host_low;
endmodule : dbg_host_model

/* File: test/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_end = 1'b0;
    ack_pkg::cmd_kind_type cmd_kind = ack_pkg::CMD_READ;
    logic exec_done = 1'b0;
    logic cpu_to_bkgnd = 1'b0;
    logic cpu_from_bkgnd = 1'b0;
    logic cpu_wait_stop = 1'b0;
    logic sync_req = 1'b0;
    logic host_low = 1'b0;
    logic oe_q = 1'b0;
    logic ack_enabled, ack_pending, ack_active, cmd_dropped;
    logic pin_in, pin_out, pin_oe, pin_level;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int t0 = 0;
    int n_drop = 0;
    int q[$];
    logic [31:0] seed = 32'h00009758;
    always #4 clk = ~clk;
    ack_handshake uut (.*);
    dbg_host_model host (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // event d >= 0 cycles after the command; ab 1 wait/stop, 2 sync, both at cycle 10
    // pulse starts after max(d, 32) clocks and the pin stage adds one more
    task automatic run(input ack_pkg::cmd_kind_type k, input int d, input int ab, input bit ack);
        if (ack) q.push_back(d > 32 ? d + 1 : 33);
        @(negedge clk);
        cmd_end = 1'b1;
        cmd_kind = k;
        t0 = cyc + 1;
        for (int i = 0; i < d + 60; i++) begin
            if (ab == 2 && (i == 11 || i == 12)) chk(pin_level, i == 12);
            if (i == 1) cmd_end = 1'b0;
            exec_done = (i == d) && (k < ack_pkg::CMD_BACKGROUND);
            cpu_to_bkgnd = (i == d) && (k == ack_pkg::CMD_BACKGROUND);
            cpu_from_bkgnd = (i == d) && (k == ack_pkg::CMD_GO);
            cpu_wait_stop = (i == 10) && (ab == 1);
            sync_req = (i == 10) && (ab == 2);
            host_low = sync_req;
            @(negedge clk);
        end
        $display("test kind %0d delay %0d done", k, d);
    endtask : run
    // pulse watcher: each rising drive takes the oldest expected latency
    always begin
        int n;
        @(negedge clk);
        if (cmd_dropped === 1'b1) n_drop++;
        if (pin_oe === 1'b1 && oe_q !== 1'b1) begin
            chk(cyc - t0, q.size() > 0 ? q.pop_front() : 16'hffff);
            n = 0;
            while (pin_oe === 1'b1 && pin_out === 1'b0 && n < 40) begin
                n++;
                @(negedge clk);
            end
            chk(n, 16);
            chk(pin_in, 1'b1);
            chk({pin_oe, pin_out}, 2'b11);
            @(negedge clk);
            chk(pin_oe, 1'b0);
        end
        oe_q = pin_oe;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chk(ack_enabled, 1'b0);
        run(ack_pkg::CMD_READ, 0, 0, 1'b0);
        run(ack_pkg::CMD_ACK_ENABLE, 0, 0, 1'b1);
        chk(ack_enabled, 1'b1);
        run(ack_pkg::CMD_READ, 32, 0, 1'b1);
        run(ack_pkg::CMD_WRITE, 33, 0, 1'b1);
        for (int j = 0; j < 10; j++) begin
            run(ack_pkg::cmd_kind_type'(j % 5), 1 + int'(rnd() % 70), 0, 1'b1);
        end
        run(ack_pkg::CMD_READ, 50, 1, 1'b0);
        chk(n_drop, 1);
        run(ack_pkg::CMD_BACKGROUND, 50, 2, 1'b0);
        run(ack_pkg::CMD_GO, 50, 2, 1'b0);
        run(ack_pkg::CMD_ACK_DISABLE, 0, 0, 1'b0);
        chk(ack_enabled, 1'b0);
        run(ack_pkg::CMD_WRITE, 5, 0, 1'b0);
        run(ack_pkg::CMD_ACK_ENABLE, 0, 0, 1'b1);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk(ack_enabled, 1'b0);
        run(ack_pkg::CMD_GO, 3, 0, 1'b0);
        chk(q.size(), 0);
        wrap_up();
    end
endmodule : testbench
